// ### logic/bpp_pkg.sv
// constants for the three bidirectional parallel ports: register indices, field positions, reset values
// assumes an apb slave with 32-bit data; register index n sits at byte address 4*n
package bpp_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W  = 10;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PORT_A_DATA      = 10'h000;
  localparam logic [IDX_W-1:0] IDX_PORT_B_DATA      = 10'h001;
  localparam logic [IDX_W-1:0] IDX_PORT_C_DATA      = 10'h002;
  localparam logic [IDX_W-1:0] IDX_PORT_A_DIRECTION = 10'h005;
  localparam logic [IDX_W-1:0] IDX_PORT_B_DIRECTION = 10'h006;
  localparam logic [IDX_W-1:0] IDX_PORT_C_DIRECTION = 10'h007;
  localparam logic [IDX_W-1:0] IDX_KEY_CONTROL      = 10'h00b;
  localparam logic [IDX_W-1:0] IDX_KEY_FLAGS        = 10'h00c;
  localparam logic [IDX_W-1:0] IDX_TONE_DAC_CONTROL = 10'h00f;
  localparam logic [IDX_W-1:0] IDX_MISC_CONTROL     = 10'h01c;

  // port widths
  localparam int unsigned PORT_A_WIDTH = 7;
  localparam int unsigned PORT_B_WIDTH = 8;
  localparam int unsigned PORT_C_WIDTH = 8;
  localparam int unsigned KEY_LINES    = 4;

  // implemented port a bits for the two variants
  localparam logic [PORT_A_WIDTH-1:0] PORT_A_FULL_MASK    = 7'h7f;
  localparam logic [PORT_A_WIDTH-1:0] PORT_A_REDUCED_MASK = 7'h7e;

  // shared pin positions on port a
  localparam int unsigned TONE_PIN    = 1;
  localparam int unsigned CAPTURE_PIN = 2;
  localparam int unsigned COMPARE_PIN = 3;

  // field positions
  localparam int unsigned TONE_DAC_PIN_ENABLE_BIT = 7;
  localparam int unsigned CAPTURE_PIN_ENABLE_BIT  = 0;
  localparam int unsigned COMPARE_PIN_ENABLE_BIT  = 1;
  localparam int unsigned KEY_IRQ_ENABLES_LSB     = 0;
  localparam int unsigned KEY_PULLUP_ENABLES_LSB  = 4;

  // values after reset
  localparam logic [7:0] DIRECTION_RESET = 8'h00;
  localparam logic [3:0] KEY_RESET       = 4'h0;

endpackage : bpp_pkg

// ### logic/bpp_port.sv
// one parallel port: output latch, direction bits and the read-back selection per pin
// assumes write strobes are single-cycle and already decoded by the bus slave
`timescale 1ns/1ps
module bpp_port #(
  parameter int unsigned        WIDTH     = 8,
  parameter logic [WIDTH-1:0]   IMPL_MASK = '1
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             writeData,
  input  wire logic             writeDirection,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [WIDTH-1:0] padIn,
  output logic      [WIDTH-1:0] readData,
  output logic      [WIDTH-1:0] latchValue,
  output logic      [WIDTH-1:0] direction
);

  typedef struct packed {
    logic [WIDTH-1:0] latch;
    logic [WIDTH-1:0] dir;
  } bpp_port_state_t;

  bpp_port_state_t state;
  bpp_port_state_t next_state;

  always_comb begin
    next_state = state;
    // the latch takes every write whatever the direction; unimplemented bits never store
    if (writeData) begin
      next_state.latch = wdata & IMPL_MASK;
    end
    if (writeDirection) begin
      next_state.dir = wdata & IMPL_MASK;
    end
    // the latch is deliberately left out of reset so data survives it
    if (srst) begin
      next_state.dir = bpp_pkg::DIRECTION_RESET[WIDTH-1:0];
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // inputs read the pin, outputs read the latch, missing bits read zero
      assign readData[i] = IMPL_MASK[i] ? (state.dir[i] ? state.latch[i] : padIn[i]) : 1'b0;
    end
  endgenerate

  assign latchValue = state.latch;
  assign direction  = state.dir;

endmodule : bpp_port

// ### logic/bpp_top.sv
// three bidirectional parallel ports with shared tone, capture, compare and keyboard pins, apb slave
// assumes pad inputs are synchronous to clk and the pad wire is resolved outside from out and oe
//
// Summary of operation
// - input pin: write only loads latch
// - output pin: write loads latch, pin driven
// - input pin: read returns pin level
// - output pin: read returns latch contents
// - data registers at 0-2, survive reset
// - direction registers 5-7, set=output, reset clears
// - port a seven lines, b and c eight
// - reduced variant drops port a bit zero
// - tone enable puts tone on port a bit1
// - capture and compare enables take bits 2,3
// - port b low nibble keyboard enables, flags, pullups
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module bpp_top #(
  parameter logic REDUCED_VARIANT = 1'b0
) (
  input  wire logic                              clk,
  input  wire logic                              srst,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [bpp_pkg::ADDR_W-1:0]        paddr,
  input  wire logic [31:0]                       pwdata,
  input  wire logic [3:0]                        pstrb,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic [bpp_pkg::PORT_A_WIDTH-1:0]  padAIn,
  output logic      [bpp_pkg::PORT_A_WIDTH-1:0]  padAOut,
  output logic      [bpp_pkg::PORT_A_WIDTH-1:0]  padAOe,
  input  wire logic [bpp_pkg::PORT_B_WIDTH-1:0]  padBIn,
  output logic      [bpp_pkg::PORT_B_WIDTH-1:0]  padBOut,
  output logic      [bpp_pkg::PORT_B_WIDTH-1:0]  padBOe,
  input  wire logic [bpp_pkg::PORT_C_WIDTH-1:0]  padCIn,
  output logic      [bpp_pkg::PORT_C_WIDTH-1:0]  padCOut,
  output logic      [bpp_pkg::PORT_C_WIDTH-1:0]  padCOe,
  input  wire logic                              toneOutput,
  input  wire logic                              compareOutput,
  output logic                                   captureInput,
  output logic      [bpp_pkg::KEY_LINES-1:0]     keyPullupEnables,
  output logic      [bpp_pkg::KEY_LINES-1:0]     keyFlags
);

  localparam int unsigned AW = bpp_pkg::PORT_A_WIDTH;
  localparam int unsigned BW = bpp_pkg::PORT_B_WIDTH;
  localparam int unsigned CW = bpp_pkg::PORT_C_WIDTH;
  localparam int unsigned KL = bpp_pkg::KEY_LINES;

  // implemented port a lines depend on the variant
  localparam logic [AW-1:0] PORT_A_MASK = REDUCED_VARIANT ? bpp_pkg::PORT_A_REDUCED_MASK
                                                          : bpp_pkg::PORT_A_FULL_MASK;

  typedef struct packed {
    logic          toneEnable;
    logic          captureEnable;
    logic          compareEnable;
    logic [KL-1:0] keyIrqEnables;
    logic [KL-1:0] keyPullups;
    logic [KL-1:0] keyFlags;
    logic [KL-1:0] keyPrev;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
    logic [AW-1:0] padAOut;
    logic [AW-1:0] padAOe;
    logic [BW-1:0] padBOut;
    logic [BW-1:0] padBOe;
    logic [CW-1:0] padCOut;
    logic [CW-1:0] padCOe;
    logic          captureInput;
  } bpp_top_state_t;

  bpp_top_state_t state;
  bpp_top_state_t next_state;

  logic [bpp_pkg::IDX_W-1:0] regIndex;
  logic                      setupPhase;
  logic                      writeTaken;
  logic                      mapped;
  logic [AW-1:0]             readA;
  logic [BW-1:0]             readB;
  logic [CW-1:0]             readC;
  logic [AW-1:0]             latchA;
  logic [BW-1:0]             latchB;
  logic [CW-1:0]             latchC;
  logic [AW-1:0]             dirA;
  logic [BW-1:0]             dirB;
  logic [CW-1:0]             dirC;
  logic                      wrDataA;
  logic                      wrDataB;
  logic                      wrDataC;
  logic                      wrDirA;
  logic                      wrDirB;
  logic                      wrDirC;
  logic [7:0]                readMux;
  logic [KL-1:0]             keyFall;

  assign regIndex   = paddr[bpp_pkg::ADDR_W-1:2];
  assign setupPhase = psel & ~penable;
  // a write lands only at the access edge that also sees pready, and only on mapped registers
  assign writeTaken = psel & penable & pwrite & state.pready & ~state.pslverr & pstrb[0];

  always_comb begin
    mapped = 1'b1;
    case (regIndex)
      bpp_pkg::IDX_PORT_A_DATA,
      bpp_pkg::IDX_PORT_B_DATA,
      bpp_pkg::IDX_PORT_C_DATA,
      bpp_pkg::IDX_PORT_A_DIRECTION,
      bpp_pkg::IDX_PORT_B_DIRECTION,
      bpp_pkg::IDX_PORT_C_DIRECTION,
      bpp_pkg::IDX_KEY_CONTROL,
      bpp_pkg::IDX_KEY_FLAGS,
      bpp_pkg::IDX_TONE_DAC_CONTROL,
      bpp_pkg::IDX_MISC_CONTROL: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  assign wrDataA = writeTaken & (regIndex == bpp_pkg::IDX_PORT_A_DATA);
  assign wrDataB = writeTaken & (regIndex == bpp_pkg::IDX_PORT_B_DATA);
  assign wrDataC = writeTaken & (regIndex == bpp_pkg::IDX_PORT_C_DATA);
  assign wrDirA  = writeTaken & (regIndex == bpp_pkg::IDX_PORT_A_DIRECTION);
  assign wrDirB  = writeTaken & (regIndex == bpp_pkg::IDX_PORT_B_DIRECTION);
  assign wrDirC  = writeTaken & (regIndex == bpp_pkg::IDX_PORT_C_DIRECTION);

  bpp_port #(
    .WIDTH          (AW),
    .IMPL_MASK      (PORT_A_MASK)
  ) u_port_a (
    .clk            (clk),
    .srst           (srst),
    .writeData      (wrDataA),
    .writeDirection (wrDirA),
    .wdata          (pwdata[AW-1:0]),
    .padIn          (padAIn),
    .readData       (readA),
    .latchValue     (latchA),
    .direction      (dirA)
  );

  bpp_port #(
    .WIDTH          (BW),
    .IMPL_MASK      ({BW{1'b1}})
  ) u_port_b (
    .clk            (clk),
    .srst           (srst),
    .writeData      (wrDataB),
    .writeDirection (wrDirB),
    .wdata          (pwdata[BW-1:0]),
    .padIn          (padBIn),
    .readData       (readB),
    .latchValue     (latchB),
    .direction      (dirB)
  );

  bpp_port #(
    .WIDTH          (CW),
    .IMPL_MASK      ({CW{1'b1}})
  ) u_port_c (
    .clk            (clk),
    .srst           (srst),
    .writeData      (wrDataC),
    .writeDirection (wrDirC),
    .wdata          (pwdata[CW-1:0]),
    .padIn          (padCIn),
    .readData       (readC),
    .latchValue     (latchC),
    .direction      (dirC)
  );

  // read value of the addressed register, taken in the setup cycle
  always_comb begin
    readMux = 8'h00;
    case (regIndex)
      bpp_pkg::IDX_PORT_A_DATA: begin
        readMux = {1'b0, readA};
      end
      bpp_pkg::IDX_PORT_B_DATA: begin
        readMux = readB;
      end
      bpp_pkg::IDX_PORT_C_DATA: begin
        readMux = readC;
      end
      bpp_pkg::IDX_PORT_A_DIRECTION: begin
        readMux = {1'b0, dirA};
      end
      bpp_pkg::IDX_PORT_B_DIRECTION: begin
        readMux = dirB;
      end
      bpp_pkg::IDX_PORT_C_DIRECTION: begin
        readMux = dirC;
      end
      bpp_pkg::IDX_KEY_CONTROL: begin
        readMux = {state.keyPullups, state.keyIrqEnables};
      end
      bpp_pkg::IDX_KEY_FLAGS: begin
        readMux = {4'h0, state.keyFlags};
      end
      bpp_pkg::IDX_TONE_DAC_CONTROL: begin
        readMux[bpp_pkg::TONE_DAC_PIN_ENABLE_BIT] = state.toneEnable;
      end
      bpp_pkg::IDX_MISC_CONTROL: begin
        readMux[bpp_pkg::CAPTURE_PIN_ENABLE_BIT] = state.captureEnable;
        readMux[bpp_pkg::COMPARE_PIN_ENABLE_BIT] = state.compareEnable;
      end
      default: begin
        readMux = 8'h00;
      end
    endcase
  end

  // falling edge on an enabled keyboard line raises its flag
  assign keyFall = state.keyPrev & ~padBIn[KL-1:0] & state.keyIrqEnables;

  always_comb begin
    next_state = state;

    // bus answer: one wait-free access phase after every setup cycle
    next_state.pready = setupPhase;
    if (setupPhase) begin
      next_state.pslverr = ~mapped;
      next_state.prdata  = (mapped && !pwrite) ? {24'h000000, readMux} : 32'h00000000;
    end else if (psel && penable && state.pready) begin
      next_state.pslverr = 1'b0;
      next_state.prdata  = 32'h00000000;
    end

    // control registers
    if (writeTaken) begin
      case (regIndex)
        bpp_pkg::IDX_KEY_CONTROL: begin
          next_state.keyIrqEnables = pwdata[bpp_pkg::KEY_IRQ_ENABLES_LSB +: KL];
          next_state.keyPullups    = pwdata[bpp_pkg::KEY_PULLUP_ENABLES_LSB +: KL];
        end
        bpp_pkg::IDX_TONE_DAC_CONTROL: begin
          next_state.toneEnable = pwdata[bpp_pkg::TONE_DAC_PIN_ENABLE_BIT];
        end
        bpp_pkg::IDX_MISC_CONTROL: begin
          next_state.captureEnable = pwdata[bpp_pkg::CAPTURE_PIN_ENABLE_BIT];
          next_state.compareEnable = pwdata[bpp_pkg::COMPARE_PIN_ENABLE_BIT];
        end
        default: begin
        end
      endcase
    end

    // flags clear by writing one; a new edge in the same cycle wins
    if (writeTaken && (regIndex == bpp_pkg::IDX_KEY_FLAGS)) begin
      next_state.keyFlags = state.keyFlags & ~pwdata[KL-1:0];
    end
    next_state.keyFlags = next_state.keyFlags | keyFall;
    next_state.keyPrev  = padBIn[KL-1:0];

    // pad drive follows the latch only while the direction bit says output
    next_state.padAOe  = dirA & PORT_A_MASK;
    next_state.padAOut = latchA & dirA & PORT_A_MASK;
    if (state.toneEnable) begin
      next_state.padAOe[bpp_pkg::TONE_PIN]  = 1'b1;
      next_state.padAOut[bpp_pkg::TONE_PIN] = toneOutput;
    end
    if (state.captureEnable) begin
      next_state.padAOe[bpp_pkg::CAPTURE_PIN]  = 1'b0;
      next_state.padAOut[bpp_pkg::CAPTURE_PIN] = 1'b0;
    end
    if (state.compareEnable) begin
      next_state.padAOe[bpp_pkg::COMPARE_PIN]  = 1'b1;
      next_state.padAOut[bpp_pkg::COMPARE_PIN] = compareOutput;
    end
    // capture sees nothing unless its pin is handed to the timer
    next_state.captureInput = state.captureEnable & padAIn[bpp_pkg::CAPTURE_PIN];
    next_state.padBOe  = dirB;
    next_state.padBOut = latchB & dirB;
    next_state.padCOe  = dirC;
    next_state.padCOut = latchC & dirC;

    if (srst) begin
      next_state.toneEnable    = 1'b0;
      next_state.captureEnable = 1'b0;
      next_state.compareEnable = 1'b0;
      next_state.keyIrqEnables = bpp_pkg::KEY_RESET;
      next_state.keyPullups    = bpp_pkg::KEY_RESET;
      next_state.keyFlags      = bpp_pkg::KEY_RESET;
      next_state.keyPrev       = bpp_pkg::KEY_RESET;
      next_state.pready        = 1'b0;
      next_state.pslverr       = 1'b0;
      next_state.prdata        = 32'h00000000;
      next_state.padAOut       = '0;
      next_state.padAOe        = '0;
      next_state.padBOut       = '0;
      next_state.padBOe        = '0;
      next_state.padCOut       = '0;
      next_state.padCOe        = '0;
      next_state.captureInput  = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  assign prdata           = state.prdata;
  assign pready           = state.pready;
  assign pslverr          = state.pslverr;
  assign padAOut          = state.padAOut;
  assign padAOe           = state.padAOe;
  assign padBOut          = state.padBOut;
  assign padBOe           = state.padBOe;
  assign padCOut          = state.padCOut;
  assign padCOe           = state.padCOe;
  assign captureInput     = state.captureInput;
  assign keyPullupEnables = state.keyPullups;
  assign keyFlags         = state.keyFlags;

endmodule : bpp_top

// ### verif/bpp_top_asserts.sv
// concurrent checks on the ports of the parallel-port block
// assumes it is bound onto bpp_top; port c carries no overrides, so it is the read-back reference
`timescale 1ns/1ps
module bpp_top_asserts (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [6:0]  padAOe,
  input wire logic [7:0]  padBOut,
  input wire logic [7:0]  padBOe,
  input wire logic [7:0]  padCIn,
  input wire logic [7:0]  padCOut,
  input wire logic [7:0]  padCOe,
  input wire logic        captureInput,
  input wire logic [3:0]  keyFlags
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_readyAfterSetup; psel && !penable |=> pready; endproperty
  a_readyAfterSetup: assert property (p_readyAfterSetup) else $error("no ready after setup");
  property p_noStrayReady; !(psel && !penable) |=> !pready; endproperty
  a_noStrayReady: assert property (p_noStrayReady) else $error("ready without setup");
  property p_resetOe; $fell(srst) |-> padAOe == 7'h00 && padBOe == 8'h00 && padCOe == 8'h00; endproperty
  a_resetOe: assert property (p_resetOe) else $error("pin driven after reset");
  property p_undrivenLow; (padBOut & ~padBOe) == 8'h00; endproperty
  a_undrivenLow: assert property (p_undrivenLow) else $error("undriven pin shows data");
  property p_latchRead;
    pready && !pwrite && !pslverr && paddr[11:2] == 10'h002 |-> (prdata[7:0] & padCOe) == (padCOut & padCOe);
  endproperty
  a_latchRead: assert property (p_latchRead) else $error("output bit read not latch");
  property p_pinRead;
    pready && !pwrite && !pslverr && paddr[11:2] == 10'h002 |-> (prdata[7:0] & ~padCOe) == ($past(padCIn) & ~padCOe);
  endproperty
  a_pinRead: assert property (p_pinRead) else $error("input bit read not pin");
  property p_unmappedErr; psel && penable && pready && paddr[11:2] == 10'h003 |-> pslverr; endproperty
  a_unmappedErr: assert property (p_unmappedErr) else $error("unmapped access without error");
  property p_aTopBit; pready && !pwrite && paddr[11:2] == 10'h000 |-> prdata[31:7] == 25'h0; endproperty
  a_aTopBit: assert property (p_aTopBit) else $error("missing port a bit reads one");
  c_error: cover property (pready && pslverr);
  c_keyFlag: cover property (keyFlags != 4'h0);
  c_capture: cover property (captureInput);
endmodule : bpp_top_asserts

bind bpp_top bpp_top_asserts uChk (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .padAOe(padAOe), .padBOut(padBOut),
  .padBOe(padBOe), .padCIn(padCIn), .padCOut(padCOut), .padCOe(padCOe), .captureInput(captureInput),
  .keyFlags(keyFlags));

// ### verif/bpp_board.sv
// board side of one port: resolves each pin from chip drive, board drive and pull-ups
// assumes the chip's enable wins; a floating pin toggles so a stale level never matches by luck
`timescale 1ns/1ps
module bpp_board #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] pinOut,
  input  wire logic [W-1:0] pinOe,
  input  wire logic [W-1:0] pullUp,
  input  wire logic [W-1:0] drvVal,
  input  wire logic [W-1:0] drvEn,
  output logic      [W-1:0] pinIn
);
  logic [W-1:0] prevLvl = '0;
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pinIn[i] = pinOe[i] ? pinOut[i] : drvEn[i] ? drvVal[i] : pullUp[i] | ~prevLvl[i];
    end
  end
  always_ff @(posedge clk) prevLvl <= pinIn;
endmodule : bpp_board

// ### verif/testbench.sv
// self-checking bench: apb register calls, then port pin checks
// assumes nothing of apb wait states: pready is sampled at each edge and only the watchdog bounds a wait
`timescale 1ns/1ps
module testbench;
  logic        clk, srst, psel, penable, pwrite, toneOutput, compareOutput, pready, pslverr, captureInput, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0]  pstrb, keyPullupEnables, keyFlags;
  logic [6:0]  padAIn, padAOut, padAOe, aDrv, aEn, padAOutR, padAOeR;
  logic [7:0]  padBIn, padBOut, padBOe, bDrv, padCIn, padCOut, padCOe, cDrv, bEn, cEn;
  int          failures, compares;
  bpp_top #(.REDUCED_VARIANT(1'b0)) uut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .padAIn(padAIn), .padAOut(padAOut), .padAOe(padAOe), .padBIn(padBIn), .padBOut(padBOut), .padBOe(padBOe),
    .padCIn(padCIn), .padCOut(padCOut), .padCOe(padCOe), .toneOutput(toneOutput), .compareOutput(compareOutput),
    .captureInput(captureInput), .keyPullupEnables(keyPullupEnables), .keyFlags(keyFlags));
  // reduced variant shares the bus; only its port a pins are watched
  bpp_top #(.REDUCED_VARIANT(1'b1)) uutReduced (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(), .pready(), .pslverr(),
    .padAIn(padAIn), .padAOut(padAOutR), .padAOe(padAOeR), .padBIn(padBIn), .padBOut(), .padBOe(),
    .padCIn(padCIn), .padCOut(), .padCOe(), .toneOutput(toneOutput), .compareOutput(compareOutput),
    .captureInput(), .keyPullupEnables(), .keyFlags());
  bpp_board #(.W(7)) brdA (.clk(clk), .pinOut(padAOut), .pinOe(padAOe), .pullUp(7'h00), .drvVal(aDrv),
    .drvEn(aEn), .pinIn(padAIn));
  bpp_board #(.W(8)) brdB (.clk(clk), .pinOut(padBOut), .pinOe(padBOe), .pullUp({4'h0, keyPullupEnables}),
    .drvVal(bDrv), .drvEn(bEn), .pinIn(padBIn));
  bpp_board #(.W(8)) brdC (.clk(clk), .pinOut(padCOut), .pinOe(padCOe), .pullUp(8'h00), .drvVal(cDrv),
    .drvEn(cEn), .pinIn(padCIn));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    // pready, read data and error are taken at the very edge that completes the access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic rd(input string what, input logic [9:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(what, rdv, {24'h0, exp});
  endtask : rd

  // pin effects land one edge after the register, so three edges leave margin
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt

  task automatic results();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    #200000;
    failures++;
    results();
  end

  initial begin
    failures = 0; compares = 0; srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0;
    pwdata = '0; pstrb = 4'hf; toneOutput = 1'b0; compareOutput = 1'b0; aDrv = 7'h00; bDrv = 8'h0f; cDrv = 8'ha5;
    aEn = 7'h7f; bEn = 8'hff; cEn = 8'hff;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd("dirA", 10'h005, 8'h00);
    rd("dirB", 10'h006, 8'h00);
    rd("dirC", 10'h007, 8'h00);
    rd("pinC", 10'h002, 8'ha5);
    apb(1'b1, 10'h002, 8'h3c);
    wt(3);
    chk("oeC", 32'(padCOe), 32'h0);
    rd("inC", 10'h002, 8'ha5);
    $display("test inputs done");
    apb(1'b1, 10'h007, 8'hff);
    wt(3);
    chk("outC", 32'(padCOut), 32'h3c);
    rd("latchC", 10'h002, 8'h3c);
    apb(1'b1, 10'h001, 8'h5a);
    apb(1'b1, 10'h006, 8'hf0);
    wt(3);
    chk("oeB", 32'(padBOe), 32'hf0);
    chk("outB", 32'(padBOut), 32'h50);
    rd("mixB", 10'h001, 8'h5f);
    $display("test outputs done");
    @(posedge clk) srst <= 1'b1;
    @(posedge clk) srst <= 1'b0;
    wt(1);
    rd("dirC", 10'h007, 8'h00);
    apb(1'b1, 10'h006, 8'hff);
    apb(1'b1, 10'h007, 8'hff);
    wt(3);
    chk("keptC", 32'(padCOut), 32'h3c);
    rd("keptB", 10'h001, 8'h5a);
    @(posedge clk) pstrb <= 4'h0;
    apb(1'b1, 10'h002, 8'h00);
    pstrb <= 4'hf;
    rd("strbC", 10'h002, 8'h3c);
    $display("test reset done");
    apb(1'b1, 10'h000, 8'hff);
    apb(1'b1, 10'h005, 8'hff);
    wt(3);
    rd("dataA", 10'h000, 8'h7f);
    chk("oeA", 32'(padAOe), 32'h7f);
    chk("oeAR", 32'(padAOeR), 32'h7e);
    chk("outAR", 32'(padAOutR), 32'h7e);
    apb(1'b1, 10'h005, 8'h00);
    apb(1'b1, 10'h00f, 8'h80);
    @(posedge clk) toneOutput <= 1'b1;
    wt(3);
    chk("toneHi", 32'({padAOe[1], padAOut[1]}), 32'h3);
    @(posedge clk) toneOutput <= 1'b0;
    wt(3);
    chk("toneLo", 32'({padAOe[1], padAOut[1]}), 32'h2);
    apb(1'b1, 10'h01c, 8'h03);
    @(posedge clk) begin
      compareOutput <= 1'b1;
      aDrv <= 7'h04;
    end
    wt(3);
    chk("cmp", 32'({padAOe[3], padAOut[3]}), 32'h3);
    chk("cap", 32'({padAOe[2], captureInput}), 32'h1);
    @(posedge clk) aDrv <= 7'h00;
    wt(3);
    chk("capLo", 32'(captureInput), 32'h0);
    $display("test shared done");
    apb(1'b1, 10'h006, 8'h00);
    apb(1'b1, 10'h00b, 8'h31);
    wt(3);
    chk("pullups", 32'(keyPullupEnables), 32'h3);
    @(posedge clk) bDrv <= 8'h0c;
    wt(3);
    chk("flagSet", 32'(keyFlags), 32'h1);
    apb(1'b1, 10'h00c, 8'h01);
    wt(2);
    chk("flagClr", 32'(keyFlags), 32'h0);
    // releasing the two low lines leaves only the pull-ups that the key control enabled
    @(posedge clk) bEn <= 8'hfc;
    rd("pullB", 10'h001, 8'h0f);
    rd("unmapped", 10'h003, 8'h00);
    chk("err", 32'(err), 32'h1);
    $display("test keys done");
    results();
  end
endmodule : testbench
